// file: logic/spi_byte.sv
`default_nettype none
// one spi byte exchange, mode 0, msb first
module spi_byte #(
   parameter int HALF = tdc_cfg_pkg::SPI_HALF_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       start_i,
   input  wire logic [7:0] tx_i,
   input  wire logic       miso_i,
   output logic            done_o,
   output logic [7:0]      rx_o,
   output logic            sck_o,
   output logic            mosi_o
);
   import tdc_cfg_pkg::*;

   logic [2:0] sy_q;   // miso synchroniser chain
   logic       miso_q; // filtered miso
   logic [7:0] sh_q;   // transmit shifter
   logic [7:0] rx_q;   // receive shifter
   logic [2:0] smp_q;  // falling edges waiting out the filter lag
   logic [4:0] ph_q;   // half periods left
   logic [7:0] dv_q;   // clock divider
   logic       sck_q;  // serial clock
   logic       done_q; // byte finished

   wire tick = dv_q == 8'(HALF - 1);
   wire run  = ph_q != 5'h00;        // clock still toggling
   wire fall = run && tick && sck_q; // falling edge this cycle
   wire busy = run || smp_q != 3'h0; // clocking or samples pending

   // miso only counts once the last two stages agree
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sy_q   <= 3'h0;
         miso_q <= 1'b0;
      end else begin
         sy_q <= {sy_q[1:0], miso_i};
         if (sy_q[1] == sy_q[2]) begin
            miso_q <= sy_q[2];
         end
      end
   end

   // shift out on falling edge; each falling edge is remembered and its
   // bit is taken three clocks later, once the pin filter has caught up,
   // so the read path holds even at a one-cycle half period
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sh_q   <= 8'h00;
         rx_q   <= 8'h00;
         smp_q  <= 3'h0;
         ph_q   <= 5'h00;
         dv_q   <= 8'h00;
         sck_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         smp_q  <= {smp_q[1:0], fall};
         done_q <= (smp_q == 3'h4) && !run; // last delayed sample lands now
         if (smp_q[2]) begin
            rx_q <= {rx_q[6:0], miso_q};
         end
         if (start_i && !busy) begin
            sh_q <= tx_i;
            ph_q <= 5'h10;
            dv_q <= 8'h00;
         end else if (run) begin
            dv_q <= tick ? 8'h00 : dv_q + 8'h01;
            if (tick) begin
               sck_q <= !sck_q;
               ph_q  <= ph_q - 5'h01;
               if (sck_q) begin
                  sh_q <= {sh_q[6:0], 1'b0};
               end
            end
         end
      end
   end

   assign done_o = done_q;
   assign rx_o   = rx_q;
   assign sck_o  = sck_q;
   assign mosi_o = sh_q[7];
endmodule
`default_nettype wire

// file: logic/tdc_cfg_pkg.sv
`default_nettype none
package tdc_cfg_pkg;
   // core clock and serial timing
   localparam int CLK_NS       = 10;  // core clock period, ns
   localparam int SER_HALF_NS  = 50;  // chip bus clock half period, ns
   localparam int SPI_HALF_NS  = 50;  // eeprom clock half period, ns
   localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int SPI_HALF_CYC = (SPI_HALF_NS + CLK_NS - 1) / CLK_NS;

   // converter chip array
   localparam int CHIPS     = 8;   // chips on the bus
   localparam int REGS      = 16;  // registers per chip
   localparam int SEQ_DEPTH = 128; // sequence entries

   // frame layout, address first on the wire
   localparam int FRAME_W   = 24;
   localparam int CHIP_LSB  = 21; // 3-bit chip address
   localparam int BCAST_BIT = 20; // broadcast flag
   localparam int REG_LSB   = 16; // 4-bit register index

   // host byte address map
   localparam logic [2:0]  REGF_PAGE = 3'h4;    // 0x800-0x9ff shadow file
   localparam logic [2:0]  SEQ_PAGE  = 3'h5;    // 0xa00-0xbff sequence
   localparam logic [11:0] END_ADDR  = 12'hc00; // end address word

   // eeprom image and opcodes
   localparam logic [8:0] EE_LAST   = 9'h180; // byte 384, image is 385 bytes
   localparam int         EE_A8_BIT = 3;      // ninth address bit in opcode
   localparam logic [7:0] OP_WREN   = 8'h06;
   localparam logic [7:0] OP_WRITE  = 8'h02;
   localparam logic [7:0] OP_READ   = 8'h03;
   localparam logic [7:0] OP_RDSR   = 8'h05;

   // reset values
   localparam logic [6:0]  END_RST   = 7'h00;
   localparam logic [23:0] FRAME_RST = 24'h000000;
endpackage
`default_nettype wire

// file: logic/tdc_config_controller.sv
`default_nettype none
// Summary of operation
// - send 24-bit frames: chip, broadcast, register, data
// - chip address goes first, chips match it
// - sixteen 16-bit write-only registers per chip
// - shadow 128x16 copy serves host read-back
// - shadow write stores word and starts sending
// - frame fields come from shadow address, data
// - 128x24 sequence RAM holds whole frames
// - programmable end address marks last entry
// - run reads entries 0 up to end
// - run frames pass through shadow write path
// - eeprom byte access with opcodes, status polling
// - own spi clock and shift register
// - image is end byte plus 384 frame bytes
// - host reads, writes shadow, sequence, eeprom
// - host commands run, save and load
// - power-up loads eeprom then runs sequence
// - direct writes at 800+40*chip+4*reg
module tdc_config_controller #(
   parameter int SER_HALF = tdc_cfg_pkg::SER_HALF_CYC,
   parameter int SPI_HALF = tdc_cfg_pkg::SPI_HALF_CYC
) (
   input  wire logic        CLK_I,
   input  wire logic        RSTN_I,
   input  wire logic        HOST_REQ_I,
   input  wire logic        HOST_WE_I,
   input  wire logic        HOST_EE_I,
   input  wire logic [11:0] HOST_ADDR_I,
   input  wire logic [23:0] HOST_WDATA_I,
   input  wire logic        CMD_RUN_I,
   input  wire logic        CMD_SAVE_I,
   input  wire logic        CMD_LOAD_I,
   output logic             HOST_ACK_O,
   output logic [23:0]      HOST_RDATA_O,
   output logic             BUSY_O,
   output logic             SER_CLK_O,
   output logic             SER_DATA_O,
   output logic             SER_FRAME_O,
   output logic             EE_CS_N_O,
   output logic             EE_SCK_O,
   output logic             EE_MOSI_O,
   input  wire logic        EE_MISO_I
);
   import tdc_cfg_pkg::*;

   // top level sequencing states
   typedef enum logic [3:0] {
      S_IDLE, S_SERW, S_HEE, S_LD, S_LDW, S_SV, S_SVW, S_RUN, S_RUNW
   } st_t;

   // eeprom byte operation states
   typedef enum logic [3:0] {
      E_IDLE, E_WREN, E_GAP, E_OP, E_ADR, E_DAT, E_RDSR, E_POLL, E_STAT
   } ee_t;

   // pick one byte of a stored frame, high byte first
   function automatic logic [7:0] frame_byte(input logic [23:0] f,
                                             input logic [1:0]  b);
      frame_byte = (b == 2'd0) ? f[23:16] : (b == 2'd1) ? f[15:8] : f[7:0];
   endfunction

   // storage
   logic [15:0] shadow_q [CHIPS*REGS]; // chip register copies
   logic [23:0] seq_q [SEQ_DEPTH];     // stored frames
   logic [6:0]  end_q;                 // last valid entry

   // sequencing
   st_t         st_q;    // main state
   logic        auto_q;  // power-up run still owed
   logic [6:0]  idx_q;   // run entry pointer
   logic [8:0]  cnt_q;   // eeprom image byte
   logic [6:0]  sidx_q;  // image frame index
   logic [1:0]  bp_q;    // byte within frame
   logic [15:0] fr_q;    // first two loaded bytes
   logic        ack_q;   // host answer pulse
   logic [23:0] rdat_q;  // host read data

   // serializer
   logic [23:0] ser_q;   // outgoing frame
   logic [4:0]  sbit_q;  // bits left minus one
   logic [7:0]  sdv_q;   // divider
   logic        sck_q;   // bus clock
   logic        sact_q;  // frame in flight
   logic        sdone_q; // frame finished

   // eeprom engine
   ee_t         es_q;    // op state
   logic        ew_q;    // op is a write
   logic [8:0]  ea_q;    // byte address
   logic [7:0]  ed_q;    // write byte
   logic [7:0]  erd_q;   // read byte
   logic        cs_q;    // chip select, high active
   logic        edone_q; // op finished
   logic        spi_done;
   logic [7:0]  spi_rx;

   // host decode
   wire idle    = st_q == S_IDLE;
   wire in_regf = HOST_ADDR_I[11:9] == REGF_PAGE;
   wire in_seq  = HOST_ADDR_I[11:9] == SEQ_PAGE;
   wire in_end  = HOST_ADDR_I == END_ADDR;
   wire [6:0] h_idx = HOST_ADDR_I[8:2]; // chip in 8:6, register in 5:2
   wire h_reg = idle && HOST_REQ_I && !HOST_EE_I;
   wire h_wr  = h_reg && HOST_WE_I;

   // host read mux, unmapped words read zero
   wire [23:0] h_rd = in_regf ? {8'h00, shadow_q[h_idx]} :
                      in_seq  ? seq_q[h_idx] :
                      in_end  ? {17'h00000, end_q} : 24'h000000;

   // one write path for host and sequencer
   wire        run_wr = st_q == S_RUN;
   wire        sh_we  = (h_wr && in_regf) || run_wr;
   wire [23:0] h_fr   = {h_idx[6:4], 1'b0, h_idx[3:0], HOST_WDATA_I[15:0]};
   wire [23:0] sh_fr  = run_wr ? seq_q[idx_q] : h_fr;
   wire [2:0]  sh_chip = sh_fr[CHIP_LSB +: 3];
   wire [3:0]  sh_reg  = sh_fr[REG_LSB +: 4];

   // sequence writes from host or from eeprom load
   wire        ld_byte = st_q == S_LDW && edone_q;
   wire        sq_ld   = ld_byte && cnt_q != 9'h000 && bp_q == 2'd2;
   wire        sq_we   = (h_wr && in_seq) || sq_ld;
   wire [6:0]  sq_idx  = sq_ld ? sidx_q : h_idx;
   wire [23:0] sq_d    = sq_ld ? {fr_q, erd_q} : HOST_WDATA_I;

   // eeprom request mux
   wire       ee_go = (idle && HOST_REQ_I && HOST_EE_I) ||
                      st_q == S_LD || st_q == S_SV;
   wire       ee_wr = idle ? HOST_WE_I : st_q == S_SV;
   wire [8:0] ee_ad = idle ? HOST_ADDR_I[8:0] : cnt_q;
   wire [7:0] sv_b  = (cnt_q == 9'h000) ? {1'b0, end_q} :
                      frame_byte(seq_q[sidx_q], bp_q);
   wire [7:0] ee_wd = idle ? HOST_WDATA_I[7:0] : sv_b;
   wire       img_end = cnt_q == EE_LAST;

   // shadow copy; a broadcast frame updates every chip's copy
   always_ff @(posedge CLK_I) begin
      for (int c = 0; c < CHIPS; c++) begin
         if (sh_we && (sh_fr[BCAST_BIT] || sh_chip == 3'(c))) begin
            shadow_q[{3'(c), sh_reg}] <= sh_fr[15:0];
         end
      end
   end

   // sequence RAM, no reset: contents come from eeprom
   always_ff @(posedge CLK_I) begin
      if (sq_we) begin
         seq_q[sq_idx] <= sq_d;
      end
   end

   // end address register
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         end_q <= END_RST;
      end else if (h_wr && in_end) begin
         end_q <= HOST_WDATA_I[6:0];
      end else if (ld_byte && cnt_q == 9'h000) begin
         end_q <= erd_q[6:0];
      end
   end

   // main sequencer; every request is taken only when idle
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         st_q   <= S_LD;   // power-up load first
         auto_q <= 1'b1;
         idx_q  <= 7'h00;
         cnt_q  <= 9'h000;
         sidx_q <= 7'h00;
         bp_q   <= 2'd0;
         fr_q   <= 16'h0000;
         ack_q  <= 1'b0;
         rdat_q <= 24'h000000;
      end else begin
         ack_q <= 1'b0;
         unique case (st_q)
            S_IDLE: begin
               idx_q  <= 7'h00;
               cnt_q  <= 9'h000;
               sidx_q <= 7'h00;
               bp_q   <= 2'd0;
               // host access wins over commands
               if (HOST_REQ_I) begin
                  if (HOST_EE_I) begin
                     st_q <= S_HEE;
                  end else if (HOST_WE_I && in_regf) begin
                     st_q <= S_SERW;
                  end else begin
                     ack_q  <= 1'b1;
                     rdat_q <= HOST_WE_I ? 24'h000000 : h_rd;
                  end
               end else if (CMD_RUN_I) begin
                  st_q <= S_RUN;
               end else if (CMD_SAVE_I) begin
                  st_q <= S_SV;
               end else if (CMD_LOAD_I) begin
                  st_q <= S_LD;
               end
            end
            S_SERW: begin
               // ack only once the frame is on the wire
               if (sdone_q) begin
                  ack_q <= 1'b1;
                  rdat_q <= 24'h000000;
                  st_q  <= S_IDLE;
               end
            end
            S_HEE: begin
               if (edone_q) begin
                  ack_q  <= 1'b1;
                  rdat_q <= {16'h0000, erd_q};
                  st_q   <= S_IDLE;
               end
            end
            S_LD, S_SV: begin
               st_q <= (st_q == S_LD) ? S_LDW : S_SVW;
            end
            S_LDW, S_SVW: begin
               if (edone_q) begin
                  // byte 0 is the end address, then frames high byte first
                  if (cnt_q != 9'h000) begin
                     fr_q <= {fr_q[7:0], erd_q};
                     bp_q <= (bp_q == 2'd2) ? 2'd0 : bp_q + 2'd1;
                     if (bp_q == 2'd2) begin
                        sidx_q <= sidx_q + 7'h01;
                     end
                  end
                  if (img_end) begin
                     auto_q <= 1'b0;
                     st_q <= (st_q == S_LDW && auto_q) ? S_RUN : S_IDLE;
                  end else begin
                     cnt_q <= cnt_q + 9'h001;
                     st_q  <= (st_q == S_LDW) ? S_LD : S_SV;
                  end
               end
            end
            S_RUN: begin
               st_q <= S_RUNW; // frame written and started this cycle
            end
            S_RUNW: begin
               if (sdone_q) begin
                  if (idx_q == end_q) begin
                     st_q <= S_IDLE;
                  end else begin
                     idx_q <= idx_q + 7'h01;
                     st_q  <= S_RUN;
                  end
               end
            end
         endcase
      end
   end

   // chip bus serializer; data changes on falling clock
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ser_q   <= FRAME_RST;
         sbit_q  <= 5'h00;
         sdv_q   <= 8'h00;
         sck_q   <= 1'b0;
         sact_q  <= 1'b0;
         sdone_q <= 1'b0;
      end else begin
         sdone_q <= 1'b0;
         if (sh_we) begin
            ser_q  <= sh_fr;
            sbit_q <= 5'(FRAME_W - 1);
            sdv_q  <= 8'h00;
            sck_q  <= 1'b0;
            sact_q <= 1'b1;
         end else if (sact_q) begin
            sdv_q <= (sdv_q == 8'(SER_HALF - 1)) ? 8'h00 : sdv_q + 8'h01;
            if (sdv_q == 8'(SER_HALF - 1)) begin
               sck_q <= !sck_q;
               if (sck_q) begin
                  ser_q  <= {ser_q[22:0], 1'b0};
                  sbit_q <= sbit_q - 5'h01;
                  if (sbit_q == 5'h00) begin
                     sact_q  <= 1'b0;
                     sdone_q <= 1'b1;
                  end
               end
            end
         end
      end
   end

   // eeprom byte sequencer; writes poll status until ready
   wire [7:0] op_b = ew_q ? (OP_WRITE | 8'({ea_q[8], 3'h0}))
                          : (OP_READ | 8'({ea_q[8], 3'h0}));
   wire       st_busy = spi_rx[0];
   wire       spi_go = (es_q == E_IDLE && ee_go) || es_q == E_GAP ||
                       es_q == E_RDSR ||
                       (spi_done && (es_q == E_OP || es_q == E_ADR ||
                                     es_q == E_POLL ||
                                     (es_q == E_STAT && st_busy)));
   wire [7:0] spi_tx = (es_q == E_IDLE) ?
                          (ee_wr ? OP_WREN
                                 : (OP_READ | 8'({ee_ad[8], 3'h0}))) :
                       (es_q == E_GAP)  ? op_b :
                       (es_q == E_RDSR) ? OP_RDSR :
                       (es_q == E_OP)   ? ea_q[7:0] :
                       (es_q == E_ADR && ew_q) ? ed_q : 8'h00;

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         es_q    <= E_IDLE;
         ew_q    <= 1'b0;
         ea_q    <= 9'h000;
         ed_q    <= 8'h00;
         erd_q   <= 8'h00;
         cs_q    <= 1'b0;
         edone_q <= 1'b0;
      end else begin
         edone_q <= 1'b0;
         unique case (es_q)
            E_IDLE: begin
               if (ee_go) begin
                  ew_q <= ee_wr;
                  ea_q <= ee_ad;
                  ed_q <= ee_wd;
                  cs_q <= 1'b1;
                  es_q <= ee_wr ? E_WREN : E_OP;
               end
            end
            E_WREN: begin
               // latch enable needs select to drop
               if (spi_done) begin
                  cs_q <= 1'b0;
                  es_q <= E_GAP;
               end
            end
            E_GAP: begin
               cs_q <= 1'b1;
               es_q <= E_OP;
            end
            E_OP: begin
               if (spi_done) begin
                  es_q <= E_ADR;
               end
            end
            E_ADR: begin
               if (spi_done) begin
                  es_q <= E_DAT;
               end
            end
            E_DAT: begin
               if (spi_done) begin
                  cs_q <= 1'b0;
                  if (ew_q) begin
                     es_q <= E_RDSR;
                  end else begin
                     erd_q   <= spi_rx;
                     edone_q <= 1'b1;
                     es_q    <= E_IDLE;
                  end
               end
            end
            E_RDSR: begin
               cs_q <= 1'b1;
               es_q <= E_POLL;
            end
            E_POLL: begin
               if (spi_done) begin
                  es_q <= E_STAT;
               end
            end
            E_STAT: begin
               // keep reading status while the write cycle runs
               if (spi_done && !st_busy) begin
                  cs_q    <= 1'b0;
                  edone_q <= 1'b1;
                  es_q    <= E_IDLE;
               end
            end
         endcase
      end
   end

   // byte shifter and eeprom clock
   spi_byte #(
      .HALF (SPI_HALF)
   ) u_spi (
      .clk_i   (CLK_I),
      .rstn_i  (RSTN_I),
      .start_i (spi_go),
      .tx_i    (spi_tx),
      .miso_i  (EE_MISO_I),
      .done_o  (spi_done),
      .rx_o    (spi_rx),
      .sck_o   (EE_SCK_O),
      .mosi_o  (EE_MOSI_O)
   );

   assign HOST_ACK_O   = ack_q;
   assign HOST_RDATA_O = rdat_q;
   assign BUSY_O       = !idle;
   assign SER_CLK_O    = sck_q;
   assign SER_DATA_O   = ser_q[FRAME_W-1];
   assign SER_FRAME_O  = sact_q;
   assign EE_CS_N_O    = !cs_q;

   // helper: rising bus clocks seen in the current frame
   logic [5:0] rise_q;
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rise_q <= 6'h00;
      end else if (sh_we) begin
         rise_q <= 6'h00;
      end else if (sact_q && !sck_q && sdv_q == 8'(SER_HALF - 1)) begin
         rise_q <= rise_q + 6'h01;
      end
   end

   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);

   sequence run_step_s;
      st_q == S_RUNW && sdone_q && idx_q != end_q;
   endsequence

   frame_len_a: assert property ($fell(sact_q) |-> rise_q == 6'd24)
      else $error("frame did not carry 24 clocks");
   frame_field_a: assert property (sh_we |=> sact_q &&
      ser_q == $past(sh_fr) && SER_DATA_O == $past(sh_fr[23]))
      else $error("frame fields differ from written word");
   shadow_store_a: assert property (sh_we && !sh_fr[BCAST_BIT] |=>
      shadow_q[$past({sh_chip, sh_reg})] == $past(sh_fr[15:0]))
      else $error("shadow copy not updated");
   readback_a: assert property (h_reg && !HOST_WE_I && in_regf |=>
      HOST_ACK_O && HOST_RDATA_O == {8'h00, shadow_q[$past(h_idx)]})
      else $error("read-back not from shadow copy");
   run_order_a: assert property (run_step_s |=> st_q == S_RUN ##0
      idx_q == $past(idx_q) + 7'h01 ##1 sact_q)
      else $error("run skipped or reordered an entry");
   run_stop_a: assert property (st_q == S_RUNW && sdone_q &&
      idx_q == end_q |=> idle && !sact_q)
      else $error("run went past end address");
   busy_ignore_a: assert property (!idle && !(st_q == S_LDW) &&
      CMD_LOAD_I |=> st_q != S_LD)
      else $error("command accepted while busy");
   ee_poll_a: assert property (es_q == E_STAT && spi_done &&
      st_busy |=> es_q == E_STAT && cs_q && !edone_q)
      else $error("status polling ended while device busy");
   power_run_a: assert property (st_q == S_LDW && edone_q &&
      img_end && auto_q |=> st_q == S_RUN ##1 st_q == S_RUNW)
      else $error("power-up run did not follow load");
endmodule
`default_nettype wire

// file: tb/ee_model.sv
`default_nettype none
// byte-wide spi eeprom, mode 0; each write leaves it busy for one status poll
module ee_model (
   input  wire logic cs_n_i,
   input  wire logic sck_i,
   input  wire logic mosi_i,
   output logic      miso_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import tdc_cfg_pkg::*;
   logic [7:0] mem [512];    // image, then free space
   logic [7:0] op, sh, tx, dat;
   logic [8:0] adr;
   logic       wen, wip;     // write latch, write in progress
   int         nb;           // bits seen since select
   wire logic [7:0] opc;     // opcode without the ninth address bit
   assign opc = op & 8'hf7;
   // end address 1: one chip frame, then one broadcast frame
   initial begin
      miso_o = 1'b0;
      wen = 1'b0;
      wip = 1'b0;
      foreach (mem[i]) mem[i] = 8'h00;
      {mem[0], mem[1], mem[2], mem[3]} = {8'h01, 24'h4f1234};
      {mem[4], mem[5], mem[6]} = 24'h1aabcd;
   end
   always @(negedge cs_n_i) nb = 0;
   // released line shows the inverse of its last bit; a write commits at deselect
   always @(posedge cs_n_i) begin
      miso_o <= ~miso_o;
      if (opc == OP_WRITE && nb >= 24 && wen) begin
         mem[adr] = dat;
         wen = 1'b0;
         wip = 1'b1;
      end
   end
   always @(posedge sck_i) if (!cs_n_i) begin
      sh = {sh[6:0], mosi_i};
      nb++;
      if (nb == 8) op = sh;
      if (nb == 8 && sh == OP_WREN) wen = 1'b1;
      if (nb == 16) adr = {op[EE_A8_BIT], sh};
      if (nb == 24) dat = sh;
   end
   // next bit goes out on the fall so it is settled before the rise
   always @(negedge sck_i) if (!cs_n_i) begin
      if (nb == 8 && opc == OP_RDSR) begin
         tx = {7'h00, wip};
         wip = 1'b0;
      end
      if (nb == 16 && opc == OP_READ) tx = mem[{op[EE_A8_BIT], sh}];
      miso_o <= tx[7];
      tx = {tx[6:0], 1'b0};
   end
endmodule
`default_nettype wire

// file: tb/tb_tdc_config_controller.sv
`default_nettype none
module tb_tdc_config_controller;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rstn, req, we, ee, run, save, load;
   logic [11:0] adr;
   logic [23:0] wd, rd, sh;
   logic [23:0] q [$];         // frames seen on the chip bus
   wire logic   ack, busy, sclk, sdat, sfr, cs_n, sck, mosi, miso;
   wire logic [23:0] hrd;
   int          miscompares, check_count, nb, i;
   // 80 ns chip bus clock; the shortest eeprom clock keeps image transfers short
   tdc_config_controller #(.SER_HALF(4), .SPI_HALF(1)) u_dut (.CLK_I(clk), .RSTN_I(rstn),
      .HOST_REQ_I(req), .HOST_WE_I(we), .HOST_EE_I(ee), .HOST_ADDR_I(adr),
      .HOST_WDATA_I(wd), .CMD_RUN_I(run), .CMD_SAVE_I(save), .CMD_LOAD_I(load),
      .HOST_ACK_O(ack), .HOST_RDATA_O(hrd), .BUSY_O(busy), .SER_CLK_O(sclk),
      .SER_DATA_O(sdat), .SER_FRAME_O(sfr), .EE_CS_N_O(cs_n), .EE_SCK_O(sck),
      .EE_MOSI_O(mosi), .EE_MISO_I(miso));
   ee_model u_ee (.cs_n_i(cs_n), .sck_i(sck), .mosi_i(mosi), .miso_o(miso));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic test_done;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait for idle, sampled 1 ns after the edge
   task automatic idle_wait;
      int n;
      for (n = 0; busy !== 1'b0; n++) begin
         if (n > 70000) begin
            miscompares++;
            test_done;
         end
         @(posedge clk);
         #1;
      end
   endtask
   // one host request pulse, then wait for the answer pulse
   task automatic acc(input logic w, e, input logic [11:0] a, input logic [23:0] d);
      int n;
      idle_wait;
      {req, we, ee, adr, wd} = {1'b1, w, e, a, d};
      @(posedge clk);
      #1 req = 1'b0;
      for (n = 0; ack !== 1'b1; n++) begin
         if (n > 5000) begin
            miscompares++;
            test_done;
         end
         @(posedge clk);
         #1;
      end
      rd = hrd;
   endtask
   // command pulse, then a request that must be ignored while busy
   task automatic cmd(input int k);
      idle_wait;
      {run, save, load} = {k == 1, k == 2, k == 3};
      @(posedge clk);
      #1 {run, save, load, req, we, ee, adr} = {6'h0c, 12'h800};
      check({23'h0, busy}, 24'h1);
      @(posedge clk);
      #1 {load, req} = 2'b00;
      repeat (3) begin
         check({23'h0, ack}, 24'h0);
         @(posedge clk);
         #1;
      end
   endtask
   // chip bus sink: chips sample on the rise inside the frame select
   always @(posedge sclk) if (sfr) begin
      sh = {sh[22:0], sdat};
      nb++;
   end
   always @(negedge sfr) if (nb != 0) begin
      check(24'(nb), 24'd24);
      q.push_back(sh);
      nb = 0;
   end
   initial begin
      {rstn, req, we, ee, run, save, load, adr, wd, nb} = '0;
      repeat (5) @(posedge clk);
      #1 rstn = 1'b1;
      idle_wait;
      check(24'(q.size()), 24'd2);
      check(q[0], 24'h4f1234);
      check(q[1], 24'h1aabcd);
      acc(0, 0, 12'h8bc, 0);
      check(rd, 24'h001234);
      acc(0, 0, 12'h968, 0);
      check(rd, 24'h00abcd);
      acc(0, 0, 12'h100, 0);
      check(rd, 24'h0);
      acc(1, 0, 12'h87c, 24'h5a5a);
      check(q[$], 24'h2f5a5a);
      acc(0, 0, 12'h87c, 0);
      check(rd, 24'h005a5a);
      for (i = 0; i < 3; i++) acc(1, 0, 12'ha00 + 12'(4 * i), 24'h0c0100 + 24'(i));
      acc(1, 0, 12'hc00, 24'h2);
      acc(0, 0, 12'ha08, 0);
      check(rd, 24'h0c0102);
      acc(0, 0, 12'hc00, 0);
      check(rd, 24'h2);
      q.delete();
      cmd(1);
      idle_wait;
      check(24'(q.size()), 24'd3);
      for (i = 0; i < 3; i++) check(q[i], 24'h0c0100 + 24'(i));
      acc(0, 0, 12'h830, 0);
      check(rd, 24'h000102);
      acc(1, 1, 12'h1ff, 24'h5c);
      acc(0, 1, 12'h1ff, 0);
      check(rd & 24'hff, 24'h5c);
      cmd(2);
      idle_wait;
      check({16'h0, u_ee.mem[0]}, 24'h2);
      check({u_ee.mem[7], u_ee.mem[8], u_ee.mem[9]}, 24'h0c0102);
      acc(1, 0, 12'ha00, 24'h777777);
      cmd(3);
      acc(0, 0, 12'ha00, 0);
      check(rd, 24'h0c0100);
      test_done;
   end
endmodule
`default_nettype wire
